// ---- rtl/dtcp_top.sv ----
`default_nettype none
module dtcp_top
  import dtcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalEventPin,
  input wire logic captureTriggerA,
  input wire logic captureTriggerB,
  output logic t0Out,
  output logic t1Out,
  output logic pwmOutA,
  output logic pwmOutAInv,
  output logic pwmOutB,
  output logic pwmOutBInv,
  output logic pwmOutC,
  output logic pwmOutCInv,
  output logic irq
);
  import dtcp_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************

  // Tick when the low k prescaler bits are all ones
  function automatic logic divTick(input logic [13:0] p, input logic [3:0] k);
    logic [13:0] m;
    m = 14'((32'h1 << k) - 32'h1);
    return (p & m) == m;
  endfunction

  // Divide exponent for the timer0 select codes
  function automatic logic [3:0] t0Exp(input logic [2:0] s);
    case (s)
      3'h0: return 4'h1;
      3'h1: return 4'h2;
      3'h2: return 4'h3;
      3'h3: return 4'h5;
      3'h4: return 4'h7;
      3'h5: return 4'h9;
      default: return 4'hB;
    endcase
  endfunction

  function automatic logic [11:0] byteAddr(input logic [9:0] idx);
    return {idx, 2'h0};
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a == byteAddr(IDX_T0DATA) || a == byteAddr(IDX_T1MODE)) begin
      hit = 1'b1;
    end
    if (a >= byteAddr(IDX_T0MODE) && a <= byteAddr(IDX_IRQCLR) && a[1:0] == 2'h0) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] t0Data, t1Data, t0Mode, t1Mode, pwmCtl;
  logic [7:0] perLo, dutyALo, dutyBLo, dutyCLo, pwmHi;
  logic [7:0] cnt0, cnt1, capAVal, capBVal;
  logic [IRQ_W-1:0] irqStatus, irqEnable;
  logic [13:0] prescale;
  logic [2:0] pinS1, pinS2, pinS3;
  logic [9:0] pwmCnt, perAct;
  logic [9:0] dutyAct [3];
  logic updPend;
  logic [1:0] updCnt;

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic setupRd = psel & ~penable & ~pwrite;
  wire logic wrEn = psel & penable & pwrite & isMapped(paddr);
  wire logic wrT0Data = wrEn && paddr == byteAddr(IDX_T0DATA);
  wire logic wrT1Mode = wrEn && paddr == byteAddr(IDX_T1MODE);
  wire logic wrT0Mode = wrEn && paddr == byteAddr(IDX_T0MODE);
  wire logic wrT1Data = wrEn && paddr == byteAddr(IDX_T1DATA);
  wire logic wrPwmCtl = wrEn && paddr == byteAddr(IDX_PWMCTL);
  wire logic wrPerLo = wrEn && paddr == byteAddr(IDX_PERLO);
  wire logic wrDutyA = wrEn && paddr == byteAddr(IDX_DUTYA);
  wire logic wrDutyB = wrEn && paddr == byteAddr(IDX_DUTYB);
  wire logic wrDutyC = wrEn && paddr == byteAddr(IDX_DUTYC);
  wire logic wrPwmHi = wrEn && paddr == byteAddr(IDX_PWMHI);
  wire logic wrIrqEn = wrEn && paddr == byteAddr(IDX_IRQEN);
  wire logic wrIrqClr = wrEn && paddr == byteAddr(IDX_IRQCLR);
  wire logic wrPwmData = wrPerLo | wrDutyA | wrDutyB | wrDutyC | wrPwmHi;

  // Zero-wait slave; read data is registered during setup
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~isMapped(paddr);

  // ****************************************
  // Mode decode
  // ****************************************
  wire logic joinWide = t1Mode[WIDE_BIT];
  wire logic firstCaptureSelect = t0Mode[CAP_BIT];
  wire logic secondCaptureSelect = t1Mode[CAP_BIT];
  wire logic pwmEn = pwmCtl[PWMEN_BIT];
  wire logic [1:0] portCode = pwmCtl[1:0];
  wire logic [2:0] firstClockSelect = t0Mode[2:0];
  wire logic [3:0] secondClockSelect = t1Mode[3:0];
  dtcp_mode_t mode;

  // Wide modes need the chained clock, else the wide bit is ignored
  always_comb begin
    if (joinWide && secondClockSelect == CK1_CHAIN) begin
      if (firstCaptureSelect && secondCaptureSelect) begin
        mode = MD_WIDECAP;
      end else if (portCode == PE_CMP) begin
        mode = MD_WIDECMP;
      end else begin
        mode = MD_WIDE;
      end
    end else if (pwmEn && portCode == PE_PWM) begin
      mode = MD_PWM;
    end else if (firstCaptureSelect && portCode == PE_CMP) begin
      mode = MD_CAPCMP;
    end else if (secondCaptureSelect) begin
      mode = MD_EVCAP;
    end else begin
      mode = MD_DUAL;
    end
  end

  logic wideMode, pwmMode, capAMode, capBMode, cap16Mode, t1TimerMode;
  always_comb begin
    wideMode = 1'b0;
    pwmMode = 1'b0;
    capAMode = 1'b0;
    capBMode = 1'b0;
    cap16Mode = 1'b0;
    t1TimerMode = 1'b0;
    case (mode)
      MD_DUAL: t1TimerMode = 1'b1;
      MD_EVCAP: begin
        capBMode = 1'b1;
        t1TimerMode = 1'b1;
      end
      MD_CAPCMP: begin
        capAMode = 1'b1;
        t1TimerMode = 1'b1;
      end
      MD_PWM: pwmMode = 1'b1;
      MD_WIDE, MD_WIDECMP: wideMode = 1'b1;
      MD_WIDECAP: begin
        wideMode = 1'b1;
        cap16Mode = 1'b1;
      end
      default: t1TimerMode = 1'b1;
    endcase
  end

  // ****************************************
  // Pin synchronisers and clock selection
  // ****************************************

  // Order: event pin, trigger A, trigger B; third stage only for edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinS1 <= 3'h0;
      pinS2 <= 3'h0;
      pinS3 <= 3'h0;
    end else begin
      pinS1 <= {captureTriggerB, captureTriggerA, externalEventPin};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end
  wire logic [2:0] pinRise = pinS2 & ~pinS3;

  // Free-running prescaler shared by both timers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prescale <= 14'h0;
    end else begin
      prescale <= prescale + 14'h1;
    end
  end

  // Event pin is sampled, so it must stay below a quarter of core_clk
  wire logic tick0 = (firstClockSelect == CK0_EXT) ? pinRise[0]
                   : divTick(prescale, t0Exp(firstClockSelect));
  wire logic tick1 = (secondClockSelect == CK1_CHAIN) ? tick0
                   : divTick(prescale, secondClockSelect);

  // ****************************************
  // Counters, comparators, capture
  // ****************************************
  wire logic run0 = t0Mode[START_BIT] & t0Mode[CONT_BIT];
  wire logic run1 = t1Mode[START_BIT] & t1Mode[CONT_BIT];
  wire logic match0 = cnt0 == t0Data;
  wire logic match1 = cnt1 == t1Data;
  wire logic match16 = {cnt1, cnt0} == {t1Data, t0Data};
  wire logic hit0 = run0 & tick0 & (wideMode ? match16 : match0);
  wire logic hit1 = run1 & tick1 & match1 & t1TimerMode;
  wire logic capEvt0 = pinRise[1] & (capAMode | cap16Mode);
  wire logic capEvt1 = pinRise[2] & capBMode;

  // Timer0 counter; in wide mode it is the low byte
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt0 <= 8'h0;
    end else if (!t0Mode[START_BIT]) begin
      cnt0 <= 8'h0;
    end else if (run0 && tick0) begin
      cnt0 <= hit0 ? 8'h0 : cnt0 + 8'h1;
    end
  end

  // Timer1 counter; carries from the low byte when joined
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt1 <= 8'h0;
    end else if (wideMode) begin
      if (!t0Mode[START_BIT] || hit0) begin
        cnt1 <= 8'h0;
      end else if (run0 && tick0 && cnt0 == 8'hFF) begin
        cnt1 <= cnt1 + 8'h1;
      end
    end else if (!t1Mode[START_BIT] || pwmMode) begin
      cnt1 <= 8'h0;
    end else if (run1 && tick1) begin
      cnt1 <= hit1 ? 8'h0 : cnt1 + 8'h1;
    end
  end

  // Capture registers catch the live count on a trigger edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      capAVal <= CAP_RST;
      capBVal <= CAP_RST;
    end else begin
      if (capEvt0) begin
        capAVal <= cnt0;
      end
      if (capEvt0 && cap16Mode) begin
        capBVal <= cnt1;
      end else if (capEvt1) begin
        capBVal <= cnt1;
      end
    end
  end

  // Compare outputs toggle on each match
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      t0Out <= 1'b0;
      t1Out <= 1'b0;
    end else begin
      if (hit0) begin
        t0Out <= ~t0Out;
      end
      if (hit1) begin
        t1Out <= ~t1Out;
      end
    end
  end

  // ****************************************
  // PWM
  // ****************************************
  wire logic [9:0] perTmp = {pwmHi[HI_P_LSB +: 2], perLo};
  wire logic [9:0] dutyTmp [3];
  assign dutyTmp[0] = {pwmHi[HI_A_LSB +: 2], dutyALo};
  assign dutyTmp[1] = {pwmHi[HI_B_LSB +: 2], dutyBLo};
  assign dutyTmp[2] = {pwmHi[HI_C_LSB +: 2], dutyCLo};
  wire logic pwmStep = pwmMode & run1 & tick1;
  wire logic perMatch = pwmStep & (pwmCnt == perAct);
  wire logic updDone = updPend & tick1 & (updCnt == UPD_SYNC_TICKS - 2'h1);
  wire logic loadAct = perMatch | updDone;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwmCnt <= 10'h0;
    end else if (!pwmMode || !t1Mode[START_BIT]) begin
      pwmCnt <= 10'h0;
    end else if (pwmStep) begin
      pwmCnt <= perMatch ? 10'h0 : pwmCnt + 10'h1;
    end
  end

  // Immediate update waits out the synchroniser before loading
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      updPend <= 1'b0;
      updCnt <= 2'h0;
    end else if (wrPwmData && pwmCtl[IMMUPD_BIT]) begin
      updPend <= 1'b1;
      updCnt <= 2'h0;
    end else if (updDone) begin
      updPend <= 1'b0;
    end else if (updPend && tick1) begin
      updCnt <= updCnt + 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      perAct <= {PWMHI_RST[HI_P_LSB +: 2], PERLO_RST};
    end else if (loadAct) begin
      perAct <= perTmp;
    end
  end

  // Three identical channels, each with a complement output
  logic [2:0] pwmHigh;
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : gCh
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          dutyAct[ch] <= {2'h0, DUTY_RST};
        end else if (loadAct) begin
          dutyAct[ch] <= dutyTmp[ch];
        end
      end
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          pwmHigh[ch] <= 1'b0;
        end else begin
          pwmHigh[ch] <= pwmMode & (pwmCnt < dutyAct[ch]);
        end
      end
    end
  endgenerate

  // Both phases stay low outside PWM mode
  logic pwmOn;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwmOn <= 1'b0;
    end else begin
      pwmOn <= pwmMode;
    end
  end
  assign pwmOutA = pwmHigh[0];
  assign pwmOutB = pwmHigh[1];
  assign pwmOutC = pwmHigh[2];
  assign pwmOutAInv = pwmOn & ~pwmHigh[0];
  assign pwmOutBInv = pwmOn & ~pwmHigh[1];
  assign pwmOutCInv = pwmOn & ~pwmHigh[2];

  // ****************************************
  // Software registers
  // ****************************************

  // Data registers should be above 0x03; smaller values are not checked
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      t0Data <= T0DATA_RST;
      t1Data <= T1DATA_RST;
      t0Mode <= MODE_RST;
      t1Mode <= MODE_RST;
      pwmCtl <= MODE_RST;
      irqEnable <= '0;
    end else begin
      if (wrT0Data) t0Data <= pwdata[7:0];
      if (wrT1Data) t1Data <= pwdata[7:0];
      if (wrT0Mode) t0Mode <= pwdata[7:0];
      if (wrT1Mode) t1Mode <= pwdata[7:0];
      if (wrPwmCtl) pwmCtl <= pwdata[7:0];
      if (wrIrqEn) irqEnable <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      perLo <= PERLO_RST;
      dutyALo <= DUTY_RST;
      dutyBLo <= DUTY_RST;
      dutyCLo <= DUTY_RST;
      pwmHi <= PWMHI_RST;
    end else begin
      if (wrPerLo) perLo <= pwdata[7:0];
      if (wrDutyA) dutyALo <= pwdata[7:0];
      if (wrDutyB) dutyBLo <= pwdata[7:0];
      if (wrDutyC) dutyCLo <= pwdata[7:0];
      if (wrPwmHi) pwmHi <= pwdata[7:0];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_W-1:0] evt;
  always_comb begin
    evt = '0;
    evt[IRQ_T0M] = hit0;
    evt[IRQ_T1M] = hit1;
    evt[IRQ_CAPA] = capEvt0;
    evt[IRQ_CAPB] = capEvt1;
    evt[IRQ_PER] = perMatch;
  end
  wire logic [IRQ_W-1:0] clrMask = wrIrqClr ? pwdata[IRQ_W-1:0] : '0;

  // An event in the clearing cycle survives: set wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= (irqStatus & ~clrMask) | evt;
    end
  end
  assign irq = |(irqStatus & irqEnable);

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h0;
    case (paddr)
      byteAddr(IDX_T0DATA): rdMux = (capAMode | cap16Mode) ? capAVal : 8'h0;
      byteAddr(IDX_T1MODE): rdMux = t1Mode;
      byteAddr(IDX_T0MODE): rdMux = t0Mode;
      byteAddr(IDX_T1DATA): rdMux = t1Data;
      byteAddr(IDX_PWMCTL): rdMux = pwmCtl;
      byteAddr(IDX_PERLO): rdMux = perLo;
      byteAddr(IDX_DUTYA): rdMux = dutyALo;
      byteAddr(IDX_DUTYB): rdMux = dutyBLo;
      byteAddr(IDX_DUTYC): rdMux = dutyCLo;
      byteAddr(IDX_PWMHI): rdMux = pwmHi;
      byteAddr(IDX_CAPB): rdMux = capBVal;
      byteAddr(IDX_IRQST): rdMux = {3'h0, irqStatus};
      byteAddr(IDX_IRQEN): rdMux = {3'h0, irqEnable};
      default: rdMux = 8'h0;
    endcase
  end

  // Sampled in setup so the access phase needs no wait state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (setupRd) begin
      prdata <= {24'h0, rdMux};
    end
  end

endmodule
`default_nettype wire

// ---- pkg/dtcp_pkg.sv ----
`default_nettype none
package dtcp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_T0DATA = 10'h0B3;
  localparam logic [9:0] IDX_T1MODE = 10'h0B4;
  localparam logic [9:0] IDX_T0MODE = 10'h0C0;
  localparam logic [9:0] IDX_T1DATA = 10'h0C1;
  localparam logic [9:0] IDX_PWMCTL = 10'h0C2;
  localparam logic [9:0] IDX_PERLO = 10'h0C3;
  localparam logic [9:0] IDX_DUTYA = 10'h0C4;
  localparam logic [9:0] IDX_DUTYB = 10'h0C5;
  localparam logic [9:0] IDX_DUTYC = 10'h0C6;
  localparam logic [9:0] IDX_PWMHI = 10'h0C7;
  localparam logic [9:0] IDX_CAPB = 10'h0C8;
  localparam logic [9:0] IDX_IRQST = 10'h0C9;
  localparam logic [9:0] IDX_IRQEN = 10'h0CA;
  localparam logic [9:0] IDX_IRQCLR = 10'h0CB;
  // Mode register fields (same layout for both timers, bit 7 only on timer 1)
  localparam int WIDE_BIT = 7;
  localparam int CAP_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int START_BIT = 4;
  // PWM control fields
  localparam int PWMEN_BIT = 7;
  localparam int IMMUPD_BIT = 6;
  // PWM high register: two bits per value
  localparam int HI_A_LSB = 6;
  localparam int HI_B_LSB = 4;
  localparam int HI_C_LSB = 2;
  localparam int HI_P_LSB = 0;
  // Reset values
  localparam logic [7:0] T0DATA_RST = 8'hFF;
  localparam logic [7:0] T1DATA_RST = 8'hFF;
  localparam logic [7:0] CAP_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PERLO_RST = 8'hFF;
  localparam logic [7:0] DUTY_RST = 8'h7F;
  localparam logic [7:0] PWMHI_RST = 8'h00;
  // Port enable codes and clock select codes
  localparam logic [1:0] PE_CMP = 2'h1;
  localparam logic [1:0] PE_PWM = 2'h3;
  localparam logic [2:0] CK0_EXT = 3'h7;
  localparam logic [3:0] CK1_CHAIN = 4'hF;
  // Update synchronisation, in timer clock ticks
  localparam logic [1:0] UPD_SYNC_TICKS = 2'h3;
  // Interrupt status bit positions
  localparam int IRQ_T0M = 0;
  localparam int IRQ_T1M = 1;
  localparam int IRQ_CAPA = 2;
  localparam int IRQ_CAPB = 3;
  localparam int IRQ_PER = 4;
  localparam int IRQ_W = 5;
  typedef enum logic [2:0] {
    MD_DUAL, MD_EVCAP, MD_CAPCMP, MD_PWM, MD_WIDE, MD_WIDECAP, MD_WIDECMP
  } dtcp_mode_t;
endpackage
`default_nettype wire

// ---- verif/dtcp_checker.sv ----
`default_nettype none
// ****
// Port checker
// ****
module dtcp_checker
  import dtcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic externalEventPin,
  input wire logic captureTriggerA,
  input wire logic captureTriggerB,
  input wire logic t0Out,
  input wire logic t1Out,
  input wire logic pwmOutA,
  input wire logic pwmOutAInv,
  input wire logic pwmOutB,
  input wire logic pwmOutBInv,
  input wire logic pwmOutC,
  input wire logic pwmOutCInv,
  input wire logic irq
);
  // Mapped window is B3, B4 and C0 to CB
  wire logic [9:0] idx = paddr[11:2];
  wire logic unmapped = paddr[1:0] != 2'h0 ||
                        !(idx == IDX_T0DATA || idx == IDX_T1MODE || (idx >= IDX_T0MODE && idx <= IDX_IRQCLR));
  // Access phase of a write, the only cycle that may clear status
  wire logic wrAccess = psel && penable && pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Read setup cycle, the only moment read data may move
  sequence s_rdSetup;
    psel && !penable && !pwrite;
  endsequence
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr;
    pslverr == (psel && penable && unmapped);
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_upper;
    prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("prdata upper bits set");
  property p_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_refuse;
    s_rdSetup ##0 unmapped |=> prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped read not zero");
  // Data at least 4 keeps matches 10 cycles apart on timer0 (divide at least 2) and 5 on timer1 (divide at least 1)
  property p_t0gap;
    $changed(t0Out) |=> $stable(t0Out) [*8];
  endproperty
  a_t0gap: assert property (p_t0gap) else $error("timer0 output too fast");
  property p_t1gap;
    $changed(t1Out) |=> $stable(t1Out) [*4];
  endproperty
  a_t1gap: assert property (p_t1gap) else $error("timer1 output too fast");
  property p_pwmExcl;
    !(pwmOutA && pwmOutAInv) && !(pwmOutB && pwmOutBInv) && !(pwmOutC && pwmOutCInv);
  endproperty
  a_pwmExcl: assert property (p_pwmExcl) else $error("pwm pair both high");
  property p_irqFall;
    $fell(irq) |-> $past(wrAccess);
  endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq dropped without write");
endmodule
bind dtcp_top dtcp_checker chk_u (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .externalEventPin(externalEventPin),
  .captureTriggerA(captureTriggerA), .captureTriggerB(captureTriggerB), .t0Out(t0Out), .t1Out(t1Out),
  .pwmOutA(pwmOutA), .pwmOutAInv(pwmOutAInv), .pwmOutB(pwmOutB), .pwmOutBInv(pwmOutBInv),
  .pwmOutC(pwmOutC), .pwmOutCInv(pwmOutCInv), .irq(irq)
);
`default_nettype wire

// ---- verif/dtcp_pin_partner.sv ----
`default_nettype none
// ****
// Pin partner: event input and capture triggers
// ****
module dtcp_pin_partner (
  input wire logic core_clk,
  output logic eventPin,
  output logic trigA,
  output logic trigB
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pins = 3'h0;
  // Idle pins rest low; events are rising edges
  assign eventPin = pins[0];
  assign trigA = pins[1];
  assign trigB = pins[2];
  // Two cycles high, then low, so the two-flop synchroniser sees each level
  task automatic pulse(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      pins[which] <= 1'b1;
      repeat (2) @(posedge core_clk);
      pins[which] <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
// ****
// Bench for the dual timer block
// ****
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dtcp_pkg::*;
  logic core_clk = 1'b0;
  logic reset, psel, penable, pwrite, pready, pslverr, t0Out, t1Out, irq;
  logic eventPin, trigA, trigB, pwmOutA, pwmAn, pwmB, pwmBn, pwmC, pwmCn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int errors = 0;
  int nChecks = 0;
  int capQ[$];
  int divT0[7] = '{2, 4, 8, 32, 128, 512, 2048};
  int selT1[4] = '{0, 3, 7, 15};
  dtcp_top dut_u (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .externalEventPin(eventPin),
    .captureTriggerA(trigA), .captureTriggerB(trigB), .t0Out(t0Out), .t1Out(t1Out), .pwmOutA(pwmOutA),
    .pwmOutAInv(pwmAn), .pwmOutB(pwmB), .pwmOutBInv(pwmBn), .pwmOutC(pwmC), .pwmOutCInv(pwmCn), .irq(irq)
  );
  dtcp_pin_partner partner_u (.core_clk(core_clk), .eventPin(eventPin), .trigA(trigA), .trigB(trigB));
  // 50 MHz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    nChecks++;
    if (seen !== expd) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A wait that runs out is a mismatch and ends the run
  task automatic bail();
    errors++;
    give_verdict();
  endtask
  // One transfer; request held until pready is seen high
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] rd);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) bail();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    apb(idx, 1'b1, d, unused);
  endtask
  task automatic rd_check(input logic [9:0] idx, input logic [31:0] expd);
    logic [31:0] v;
    apb(idx, 1'b0, 8'h00, v);
    check(v, expd);
  endtask
  // Cycles between the first and second change of a timer output
  task automatic gap(input bit useT1, output int cyc);
    logic old;
    @(negedge core_clk);
    for (int r = 0; r < 2; r++) begin
      old = useT1 ? t1Out : t0Out;
      cyc = 0;
      do begin
        @(negedge core_clk);
        cyc++;
      end while ((useT1 ? t1Out : t0Out) === old && cyc < 30000);
      if (cyc >= 30000) bail();
    end
  endtask
  task automatic wait_lvl(input bit chB, input logic lvl);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while ((chB ? pwmB : pwmOutA) !== lvl && k < 3000);
    if (k >= 3000) bail();
  endtask
  // High time of the next pulse, optionally rewriting duty A just after it rises
  task automatic high_len(input bit chB, input bit doWr, input logic [7:0] val, output int len);
    longint t;
    wait_lvl(chB, 1'b0);
    wait_lvl(chB, 1'b1);
    t = $time;
    if (doWr) wr(IDX_DUTYA, val);
    wait_lvl(chB, 1'b0);
    len = int'(($time - t) / 20);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    int d, cyc, n, total, len;
    logic lvl;
    logic [7:0] v;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    total = 0;
    void'($urandom(11676));
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd_check(IDX_T0DATA, 32'h0);
    rd_check(IDX_T1MODE, 32'h0);
    v = 8'($urandom_range(255)) & 8'hEF;
    wr(IDX_T1MODE, v);
    rd_check(IDX_T1MODE, {24'h0, v});
    wr(IDX_T1MODE, 8'h00);
    wr(10'h0D0, 8'h55);
    rd_check(10'h0D0, 32'h0);
    // Timer0 on every prescaler tap
    for (int s = 0; s < 7; s++) begin
      d = 4 + $urandom_range(3);
      wr(IDX_T0MODE, 8'h00);
      wr(IDX_T0DATA, d[7:0]);
      wr(IDX_T0MODE, 8'h30 | s[7:0]);
      gap(1'b0, cyc);
      check(cyc, (d + 1) * divT0[s]);
    end
    rd_check(IDX_T0DATA, 32'h0);
    // Timer1 taps, chain code borrows the timer0 divide by 4
    wr(IDX_T0MODE, 8'h31);
    foreach (selT1[i]) begin
      d = 4 + $urandom_range(3);
      wr(IDX_T1MODE, 8'h00);
      wr(IDX_T1DATA, d[7:0]);
      wr(IDX_T1MODE, 8'h30 | selT1[i][7:0]);
      gap(1'b1, cyc);
      check(cyc, (d + 1) * (selT1[i] == 15 ? 4 : (1 << selT1[i])));
    end
    // Joined 16-bit count of 0x0104 on divide by 2
    wr(IDX_T0MODE, 8'h00);
    wr(IDX_T1MODE, 8'h00);
    wr(IDX_T0DATA, 8'h04);
    wr(IDX_T1DATA, 8'h01);
    wr(IDX_T1MODE, 8'h8F);
    wr(IDX_T0MODE, 8'h30);
    gap(1'b0, cyc);
    check(cyc, 261 * 2);
    wr(IDX_T1MODE, 8'h00);
    // Event counting: data pulses leave the output alone, one more toggles it
    wr(IDX_T0MODE, 8'h00);
    d = 4 + $urandom_range(3);
    wr(IDX_T0DATA, d[7:0]);
    wr(IDX_T0MODE, 8'h37);
    @(negedge core_clk);
    lvl = t0Out;
    partner_u.pulse(0, d);
    repeat (6) @(negedge core_clk);
    check(t0Out, lvl);
    partner_u.pulse(0, 1);
    repeat (6) @(negedge core_clk);
    check(t0Out, !lvl);
    // Capture of the event count, model kept in a queue
    wr(IDX_T0MODE, 8'h00);
    wr(IDX_PWMCTL, {6'h0, PE_CMP});
    wr(IDX_T0DATA, 8'hF0);
    wr(IDX_T0MODE, 8'h77);
    rd_check(IDX_T0DATA, 32'h0);
    for (int i = 0; i < 2; i++) begin
      n = 1 + $urandom_range(9);
      total += n;
      capQ.push_back(total);
      partner_u.pulse(0, n);
      repeat (6) @(negedge core_clk);
      partner_u.pulse(1, 1);
      repeat (6) @(negedge core_clk);
      rd_check(IDX_T0DATA, capQ.pop_front());
    end
    // Capture event raises, clears and masks the interrupt
    wr(IDX_IRQCLR, 8'h1F);
    wr(IDX_IRQEN, 8'h04);
    @(negedge core_clk);
    check(irq, 1'b0);
    partner_u.pulse(1, 1);
    repeat (6) @(negedge core_clk);
    check(irq, 1'b1);
    rd_check(IDX_IRQST, 32'h04);
    wr(IDX_IRQCLR, 8'h04);
    @(negedge core_clk);
    check(irq, 1'b0);
    wr(IDX_IRQEN, 8'h00);
    partner_u.pulse(1, 1);
    repeat (6) @(negedge core_clk);
    check(irq, 1'b0);
    wr(IDX_IRQEN, 8'h04);
    @(negedge core_clk);
    check(irq, 1'b1);
    // PWM with period 1023 so mid-period updates are visible
    wr(IDX_PWMCTL, 8'h83);
    wr(IDX_PERLO, 8'hFF);
    wr(IDX_PWMHI, 8'h03);
    wr(IDX_DUTYA, 8'd20);
    wr(IDX_T1MODE, 8'h30);
    high_len(1'b0, 1'b0, 8'h00, len);
    high_len(1'b0, 1'b0, 8'h00, len);
    check(len, 20);
    high_len(1'b0, 1'b1, 8'd200, len);
    check(len, 20);
    high_len(1'b0, 1'b0, 8'h00, len);
    check(len, 200);
    check(pwmAn, !pwmOutA);
    wr(IDX_PWMCTL, 8'hC3);
    high_len(1'b0, 1'b1, 8'd60, len);
    check(len, 60);
    high_len(1'b1, 1'b0, 8'h00, len);
    check(len, 32'h7F);
    check({pwmB, pwmBn, pwmC, pwmCn}, 32'h5);
    give_verdict();
  end
endmodule
`default_nettype wire
